// >>> src/fpc_pkg.sv
package fpc_pkg;

    // =========================================================
    // formats and field layout
    // =========================================================
    localparam int OP_W = 96;

    typedef enum logic [1:0] {
        FPC_FMT_SGL = 2'h0,
        FPC_FMT_DBL = 2'h1,
        FPC_FMT_EXT = 2'h2,
        FPC_FMT_PKD = 2'h3
    } fpc_fmt_t;

    // single
    localparam int SGL_EXP_W = 8;
    localparam int SGL_FRC_W = 23;
    localparam int SGL_SIGN  = 31;
    // double
    localparam int DBL_EXP_W = 11;
    localparam int DBL_FRC_W = 52;
    localparam int DBL_SIGN  = 63;
    // extended: sign 95, exponent 94..80, integer bit 63, mantissa 62..0
    localparam int EXT_EXP_W = 15;
    localparam int EXT_FRC_W = 63;
    localparam int EXT_SIGN  = 95;
    localparam int EXT_EXP_L = 80;
    localparam int EXT_JBIT  = 63;
    // packed decimal: mantissa sign 95, exponent sign 94, yy 93..92
    localparam int PKD_SM    = 95;
    localparam int PKD_YY_H  = 93;
    localparam int PKD_YY_L  = 92;
    localparam int PKD_DIG_W = 68;

    // widest fraction, stored left-aligned in the working mantissa
    localparam int MAN_W     = 64;
    localparam int REXP_W    = 17;

    // =========================================================
    // classes
    // =========================================================
    typedef enum logic [6:0] {
        FPC_NORM  = 7'h01,
        FPC_DENRM = 7'h02,
        FPC_UNNRM = 7'h04,
        FPC_ZERO  = 7'h08,
        FPC_INF   = 7'h10,
        FPC_QNAN  = 7'h20,
        FPC_SNAN  = 7'h40
    } fpc_class_t;

    typedef struct packed {
        fpc_class_t cls;
        logic       sign;
        logic       unimp_trap;
    } fpc_info_t;

    // result presented for range check and gradual underflow
    typedef struct packed {
        logic              sign;
        logic [REXP_W-1:0] exp;   // biased, signed
        logic [MAN_W-1:0]  man;   // explicit integer bit at top
    } fpc_res_t;

endpackage : fpc_pkg

// >>> src/fpc_classify.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================
// combinational classifier for one operand
// =============================================================
module fpc_classify (
    input  wire logic [fpc_pkg::OP_W-1:0] op,
    input  wire fpc_pkg::fpc_fmt_t        fmt,
    output fpc_pkg::fpc_info_t            info
);
    logic                         sign;
    logic                         e_min;
    logic                         e_max;
    logic                         frac_nz;
    logic                         qbit;
    logic                         jbit;
    logic [fpc_pkg::EXT_EXP_W-1:0] e_ext;

    // field extraction per format
    always_comb begin
        e_ext   = op[fpc_pkg::EXT_EXP_L +: fpc_pkg::EXT_EXP_W];
        jbit    = 1'b1;
        unique case (fmt)
            fpc_pkg::FPC_FMT_SGL: begin
                sign    = op[fpc_pkg::SGL_SIGN];
                e_min   = ~|op[fpc_pkg::SGL_FRC_W +: fpc_pkg::SGL_EXP_W];
                e_max   = &op[fpc_pkg::SGL_FRC_W +: fpc_pkg::SGL_EXP_W];
                frac_nz = |op[fpc_pkg::SGL_FRC_W-1:0];
                qbit    = op[fpc_pkg::SGL_FRC_W-1];
            end
            fpc_pkg::FPC_FMT_DBL: begin
                sign    = op[fpc_pkg::DBL_SIGN];
                e_min   = ~|op[fpc_pkg::DBL_FRC_W +: fpc_pkg::DBL_EXP_W];
                e_max   = &op[fpc_pkg::DBL_FRC_W +: fpc_pkg::DBL_EXP_W];
                frac_nz = |op[fpc_pkg::DBL_FRC_W-1:0];
                qbit    = op[fpc_pkg::DBL_FRC_W-1];
            end
            fpc_pkg::FPC_FMT_EXT: begin
                sign    = op[fpc_pkg::EXT_SIGN];
                e_min   = ~|e_ext;
                e_max   = &e_ext;
                frac_nz = |op[fpc_pkg::EXT_FRC_W-1:0];
                // extended quiet bit below integer bit
                qbit    = op[fpc_pkg::EXT_FRC_W-1];
                jbit    = op[fpc_pkg::EXT_JBIT];
            end
            default: begin
                // packed: yy all-ones marks infinity or NaN
                sign    = op[fpc_pkg::PKD_SM];
                e_min   = 1'b0;
                e_max   = &op[fpc_pkg::PKD_YY_H:fpc_pkg::PKD_YY_L];
                frac_nz = |op[fpc_pkg::PKD_DIG_W-1:0];
                qbit    = op[fpc_pkg::EXT_FRC_W-1];
            end
        endcase
    end

    // one class per operand
    always_comb begin
        info.sign       = sign;
        info.unimp_trap = 1'b0;
        if (fmt == fpc_pkg::FPC_FMT_PKD) begin
            if (e_max)
                info.cls = !frac_nz ? fpc_pkg::FPC_INF
                         : qbit ? fpc_pkg::FPC_QNAN : fpc_pkg::FPC_SNAN;
            else
                info.cls = frac_nz ? fpc_pkg::FPC_NORM : fpc_pkg::FPC_ZERO;
        end else if (e_max) begin
            if (!frac_nz)
                info.cls = fpc_pkg::FPC_INF;
            // quiet when top fraction bit set
            else if (qbit)
                info.cls = fpc_pkg::FPC_QNAN;
            else
                info.cls = fpc_pkg::FPC_SNAN;
        end else if (fmt == fpc_pkg::FPC_FMT_EXT) begin
            if (jbit)
                info.cls = fpc_pkg::FPC_NORM;
            else if (!e_min)
                info.cls = fpc_pkg::FPC_UNNRM;
            // signed zero only at minimum exponent
            else if (!frac_nz)
                info.cls = fpc_pkg::FPC_ZERO;
            // extended denormal has integer bit zero
            else
                info.cls = fpc_pkg::FPC_DENRM;
        end else if (e_min) begin
            info.cls = frac_nz ? fpc_pkg::FPC_DENRM : fpc_pkg::FPC_ZERO;
        end else begin
            info.cls = fpc_pkg::FPC_NORM;
        end
        info.unimp_trap = (info.cls == fpc_pkg::FPC_DENRM) ||
                          (info.cls == fpc_pkg::FPC_UNNRM);
    end
endmodule : fpc_classify
`default_nettype wire

// >>> src/fpc_unit.sv
`timescale 1ns/10ps
`default_nettype none
// =============================================================
// operand classes, NaN handling, range detect, gradual underflow
// =============================================================
module fpc_unit #(
    parameter int MAN_W = fpc_pkg::MAN_W
) (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic                      op_valid,
    input  wire fpc_pkg::fpc_fmt_t         op_fmt,
    input  wire logic [fpc_pkg::OP_W-1:0]  op_a,
    input  wire logic [fpc_pkg::OP_W-1:0]  op_b,
    input  wire logic                      invalid_op,
    input  wire logic                      snan_trap_en,
    input  wire logic                      res_valid,
    input  wire fpc_pkg::fpc_fmt_t         res_fmt,
    input  wire fpc_pkg::fpc_res_t         res_in,
    output fpc_pkg::fpc_info_t             info_a_q,
    output fpc_pkg::fpc_info_t             info_b_q,
    output logic                           info_valid_q,
    output logic                           unimp_trap_q,
    output logic                           snan_event_q,
    output logic                           nan_out_q,
    output logic [fpc_pkg::OP_W-1:0]       nan_word_q,
    output logic                           unfl_q,
    output logic                           ovfl_q,
    output logic                           res_busy,
    output logic                           res_done_q,
    output fpc_pkg::fpc_res_t              res_out_q
);
    // =========================================================
    // elaboration checks
    // =========================================================
    if (MAN_W != fpc_pkg::MAN_W) begin : g_bad_man
        $error("fpc_unit: MAN_W must match the working mantissa");
    end

    fpc_pkg::fpc_info_t info_a;
    fpc_pkg::fpc_info_t info_b;

    // =========================================================
    // classification of both operands
    // =========================================================
    fpc_classify u_cls_a (
        .op   (op_a),
        .fmt  (op_fmt),
        .info (info_a)
    );
    fpc_classify u_cls_b (
        .op   (op_b),
        .fmt  (op_fmt),
        .info (info_b)
    );

    // all-ones exponent in the given format, placed in its field
    function automatic logic [fpc_pkg::OP_W-1:0] nan_base(
        input fpc_pkg::fpc_fmt_t f,
        input logic              s
    );
        logic [fpc_pkg::OP_W-1:0] w;
        w = '0;
        unique case (f)
            fpc_pkg::FPC_FMT_SGL: begin
                w[fpc_pkg::SGL_SIGN] = s;
                w[fpc_pkg::SGL_FRC_W +: fpc_pkg::SGL_EXP_W] = '1;
            end
            fpc_pkg::FPC_FMT_DBL: begin
                w[fpc_pkg::DBL_SIGN] = s;
                w[fpc_pkg::DBL_FRC_W +: fpc_pkg::DBL_EXP_W] = '1;
            end
            default: begin
                w[fpc_pkg::EXT_SIGN] = s;
                w[fpc_pkg::EXT_EXP_L +: fpc_pkg::EXT_EXP_W] = '1;
            end
        endcase
        return w;
    endfunction : nan_base

    // the quiet bit position in the given format
    function automatic int qbit_pos(input fpc_pkg::fpc_fmt_t f);
        unique case (f)
            fpc_pkg::FPC_FMT_SGL: return fpc_pkg::SGL_FRC_W - 1;
            fpc_pkg::FPC_FMT_DBL: return fpc_pkg::DBL_FRC_W - 1;
            default:              return fpc_pkg::EXT_FRC_W - 1;
        endcase
    endfunction : qbit_pos

    // =========================================================
    // NaN result selection
    // =========================================================
    logic                     is_nan_a;
    logic                     is_nan_b;
    logic                     nan_out_d;
    logic                     snan_event_d;
    logic [fpc_pkg::OP_W-1:0] nan_word_d;
    logic [fpc_pkg::OP_W-1:0] src_nan;

    always_comb begin
        is_nan_a = (info_a.cls == fpc_pkg::FPC_QNAN) ||
                   (info_a.cls == fpc_pkg::FPC_SNAN);
        is_nan_b = (info_b.cls == fpc_pkg::FPC_QNAN) ||
                   (info_b.cls == fpc_pkg::FPC_SNAN);
        snan_event_d = op_valid && ((info_a.cls == fpc_pkg::FPC_SNAN) ||
                                    (info_b.cls == fpc_pkg::FPC_SNAN));
        nan_out_d = op_valid && (is_nan_a || is_nan_b || invalid_op);
        // source NaN: operand a wins when both are NaN
        src_nan = is_nan_a ? op_a : op_b;
        if (is_nan_a || is_nan_b) begin
            // set quiet bit of the source
            nan_word_d = src_nan;
            nan_word_d[qbit_pos(op_fmt)] = 1'b1;
        end else begin
            nan_word_d = nan_base(op_fmt, 1'b0);
            if (op_fmt == fpc_pkg::FPC_FMT_SGL)
                nan_word_d[fpc_pkg::SGL_FRC_W-1:0] = '1;
            else if (op_fmt == fpc_pkg::FPC_FMT_DBL)
                nan_word_d[fpc_pkg::DBL_FRC_W-1:0] = '1;
            else
                nan_word_d[fpc_pkg::EXT_JBIT:0] = '1;
        end
        // a trapped signalling NaN delivers no result
        if (snan_event_d && snan_trap_en)
            nan_out_d = 1'b0;
    end

    // classification registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            info_a_q     <= '{cls: fpc_pkg::FPC_ZERO, default: 1'b0};
            info_b_q     <= '{cls: fpc_pkg::FPC_ZERO, default: 1'b0};
            info_valid_q <= 1'b0;
            unimp_trap_q <= 1'b0;
            snan_event_q <= 1'b0;
            nan_out_q    <= 1'b0;
            nan_word_q   <= '0;
        end else begin
            info_a_q     <= info_a;
            info_b_q     <= info_b;
            info_valid_q <= op_valid;
            unimp_trap_q <= op_valid && (info_a.unimp_trap ||
                                         info_b.unimp_trap);
            snan_event_q <= snan_event_d;
            nan_out_q    <= nan_out_d;
            nan_word_q   <= nan_out_d ? nan_word_d : '0;
        end
    end

    // =========================================================
    // result range check and gradual underflow
    // =========================================================
    typedef enum logic [1:0] {
        FPC_ST_IDLE  = 2'b01,
        FPC_ST_SHIFT = 2'b10
    } fpc_state_t;

    fpc_state_t        st_q;
    fpc_state_t        st_d;
    fpc_pkg::fpc_res_t work_q;
    fpc_pkg::fpc_res_t work_d;
    logic [fpc_pkg::REXP_W-1:0] emax;
    logic              unfl_d;
    logic              ovfl_d;
    logic              done_d;
    fpc_pkg::fpc_res_t out_d;

    // maximum exponent of each destination format: all ones in its exponent width
    function automatic logic [fpc_pkg::REXP_W-1:0] fmt_max(
        input fpc_pkg::fpc_fmt_t f
    );
        unique case (f)
            fpc_pkg::FPC_FMT_SGL:
                return {{(fpc_pkg::REXP_W-fpc_pkg::SGL_EXP_W){1'b0}},
                        {fpc_pkg::SGL_EXP_W{1'b1}}};
            fpc_pkg::FPC_FMT_DBL:
                return {{(fpc_pkg::REXP_W-fpc_pkg::DBL_EXP_W){1'b0}},
                        {fpc_pkg::DBL_EXP_W{1'b1}}};
            default:
                return {{(fpc_pkg::REXP_W-fpc_pkg::EXT_EXP_W){1'b0}},
                        {fpc_pkg::EXT_EXP_W{1'b1}}};
        endcase
    endfunction : fmt_max

    always_comb begin
        st_d    = st_q;
        work_d  = work_q;
        unfl_d  = 1'b0;
        ovfl_d  = 1'b0;
        done_d  = 1'b0;
        out_d   = res_out_q;
        emax    = fmt_max(res_fmt);
        unique case (st_q)
            FPC_ST_IDLE: begin
                if (res_valid) begin
                    if (!res_in.exp[fpc_pkg::REXP_W-1] &&
                        res_in.exp >= emax) begin
                        ovfl_d = 1'b1;
                        done_d = 1'b1;
                        out_d  = res_in;
                    end else if (res_in.exp[fpc_pkg::REXP_W-1] ||
                                 res_in.exp == '0) begin
                        unfl_d = 1'b1;
                        work_d = res_in;
                        st_d   = FPC_ST_SHIFT;
                    end else begin
                        done_d = 1'b1;
                        out_d  = res_in;
                    end
                end
            end
            FPC_ST_SHIFT: begin
                // shift right, bump exponent to minimum
                if (work_q.exp[fpc_pkg::REXP_W-1] && |work_q.man) begin
                    work_d.man = work_q.man >> 1;
                    work_d.exp = work_q.exp + 1'b1;
                end else begin
                    // exponent at minimum or all bits gone: deliver with exponent forced to zero
                    out_d     = work_q;
                    out_d.exp = '0;
                    done_d    = 1'b1;
                    st_d      = FPC_ST_IDLE;
                end
            end
            default: st_d = FPC_ST_IDLE;
        endcase
    end

    // new results are held off while a denormalization runs
    assign res_busy = (st_q != FPC_ST_IDLE);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q       <= FPC_ST_IDLE;
            work_q     <= '0;
            unfl_q     <= 1'b0;
            ovfl_q     <= 1'b0;
            res_done_q <= 1'b0;
            res_out_q  <= '0;
        end else begin
            st_q       <= st_d;
            work_q     <= work_d;
            unfl_q     <= unfl_d;
            ovfl_q     <= ovfl_d;
            res_done_q <= done_d;
            res_out_q  <= out_d;
        end
    end
endmodule : fpc_unit
`default_nettype wire

// >>> testbench/fpc_unit_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// operand unit properties
// ==========================================================
module fpc_unit_properties #(
    parameter int MAN_W = fpc_pkg::MAN_W
) (
    input wire logic                      core_clk,
    input wire logic                      resetn,
    input wire logic                      op_valid,
    input wire fpc_pkg::fpc_fmt_t         op_fmt,
    input wire logic                      invalid_op,
    input wire logic                      snan_trap_en,
    input wire logic                      res_valid,
    input wire fpc_pkg::fpc_fmt_t         res_fmt,
    input wire fpc_pkg::fpc_res_t         res_in,
    input wire fpc_pkg::fpc_info_t        info_a_q,
    input wire logic                      info_valid_q,
    input wire logic                      unimp_trap_q,
    input wire logic                      snan_event_q,
    input wire logic                      nan_out_q,
    input wire logic [fpc_pkg::OP_W-1:0]  nan_word_q,
    input wire logic                      unfl_q,
    input wire logic                      ovfl_q,
    input wire logic                      res_busy,
    input wire logic                      res_done_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // result taken; one-bit gradual underflow steps
    sequence res_take;
        res_valid && !res_busy;
    endsequence
    sequence uf_one_shift;
        unfl_q && !res_done_q ##1 !res_done_q ##1 res_done_q;
    endsequence

    info_follow_a: assert property (op_valid |=> info_valid_q)
        else $error("class answer late");
    class_onehot_a: assert property (info_valid_q |-> $onehot(info_a_q.cls))
        else $error("class not one-hot");
    unimp_trap_a: assert property (info_valid_q && info_a_q.cls inside
        {fpc_pkg::FPC_DENRM, fpc_pkg::FPC_UNNRM} |-> unimp_trap_q)
        else $error("trap missing");
    snan_seen_a: assert property (info_valid_q
        && info_a_q.cls == fpc_pkg::FPC_SNAN |-> snan_event_q)
        else $error("snan event missing");
    nan_prop_a: assert property (info_valid_q
        && info_a_q.cls == fpc_pkg::FPC_QNAN && !snan_event_q |-> nan_out_q)
        else $error("quiet nan not passed");
    sgl_quiet_a: assert property (nan_out_q &&
        $past(op_fmt) == fpc_pkg::FPC_FMT_SGL |-> nan_word_q[30:22] == 9'h1ff)
        else $error("single nan not quiet");
    invalid_nan_a: assert property (op_valid && invalid_op
        && !snan_trap_en |=> nan_out_q)
        else $error("invalid op gave no nan");
    ovfl_flag_a: assert property ((res_take ##0
        (res_fmt == fpc_pkg::FPC_FMT_SGL && !res_in.exp[16]
        && res_in.exp >= 17'h000ff)) |=> ovfl_q && res_done_q)
        else $error("overflow missed");
    unfl_flag_a: assert property ((res_take ##0
        (res_in.exp[16] || res_in.exp == 17'h00000)) |=> unfl_q)
        else $error("underflow missed");
    gradual_walk_a: assert property ((res_take ##0
        (res_in.exp == 17'h1ffff && res_in.man[MAN_W-1])) |=> uf_one_shift)
        else $error("gradual shift timing wrong");
    norm_range_a: assert property ((res_take ##0
        (res_fmt == fpc_pkg::FPC_FMT_SGL
        && res_in.exp inside {[17'h00001:17'h000fe]}))
        |=> !unfl_q && !ovfl_q && res_done_q)
        else $error("in-range result wrong");
endmodule : fpc_unit_properties

bind fpc_unit fpc_unit_properties #(.MAN_W(MAN_W)) u_props (
    .core_clk, .resetn, .op_valid, .op_fmt, .invalid_op, .snan_trap_en,
    .res_valid, .res_fmt, .res_in, .info_a_q, .info_valid_q,
    .unimp_trap_q, .snan_event_q, .nan_out_q, .nan_word_q, .unfl_q,
    .ovfl_q, .res_busy, .res_done_q
);
`default_nettype wire

// >>> testbench/fpc_res_src.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// datapath side: result source
// ==========================================================
module fpc_res_src (
    input  wire logic         core_clk,
    input  wire logic         res_busy,
    output fpc_pkg::fpc_res_t res_in,
    output fpc_pkg::fpc_fmt_t res_fmt,
    output logic              res_valid
);
    // idle at time zero
    initial begin
        res_valid = 1'b0;
        res_fmt   = fpc_pkg::FPC_FMT_SGL;
        res_in    = '0;
    end
    // held until taken; gap slows the source
    task automatic send(input fpc_pkg::fpc_fmt_t f,
                        input fpc_pkg::fpc_res_t r, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        res_valid = 1'b1;
        res_fmt   = f;
        res_in    = r;
        while (res_busy) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1;
        res_valid = 1'b0;
        res_in    = ~r; // stale data must not look valid
    endtask : send
endmodule : fpc_res_src
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic              core_clk, resetn, op_valid, invalid_op, snan_trap_en;
    fpc_pkg::fpc_fmt_t op_fmt, res_fmt;
    logic [95:0]       op_a, op_b, nan_word_q;
    fpc_pkg::fpc_res_t res_in, res_out_q;
    fpc_pkg::fpc_info_t info_a_q, info_b_q;
    logic              info_valid_q, unimp_trap_q, snan_event_q, nan_out_q;
    logic              unfl_q, ovfl_q, res_busy, res_done_q, res_valid;
    int                bad_count, checks_done, cycles;
    localparam fpc_pkg::fpc_fmt_t SGL = fpc_pkg::FPC_FMT_SGL,
        DBL = fpc_pkg::FPC_FMT_DBL, EXT = fpc_pkg::FPC_FMT_EXT,
        PKD = fpc_pkg::FPC_FMT_PKD;

    fpc_unit dut (.core_clk, .resetn, .op_valid, .op_fmt, .op_a, .op_b,
        .invalid_op, .snan_trap_en, .res_valid, .res_fmt, .res_in,
        .info_a_q, .info_b_q, .info_valid_q, .unimp_trap_q, .snan_event_q,
        .nan_out_q, .nan_word_q, .unfl_q, .ovfl_q, .res_busy, .res_done_q,
        .res_out_q);
    fpc_res_src u_src (.core_clk, .res_busy, .res_in, .res_fmt, .res_valid);

    // ======================================================
    // compare tasks
    // ======================================================
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk_bit
    task automatic chk_cls(input string n, input fpc_pkg::fpc_class_t e,
                           input fpc_pkg::fpc_class_t g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk_cls
    task automatic chk_word(input string n, input logic [95:0] e,
                            input logic [95:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk_word
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // ======================================================
    // scenarios
    // ======================================================
    task automatic apply(input fpc_pkg::fpc_fmt_t f, input logic [95:0] a,
                         input logic [95:0] b, input logic inv, trap);
        @(posedge core_clk);
        #1;
        op_valid     = 1'b1;
        op_fmt       = f;
        op_a         = a;
        op_b         = b;
        invalid_op   = inv;
        snan_trap_en = trap;
        @(posedge core_clk);
        #1;
        op_valid     = 1'b0;
        invalid_op   = 1'b0;
        chk_bit("info_valid_q", 1'b1, info_valid_q);
    endtask : apply
    // one operand, zero partner
    task automatic cls_case(input fpc_pkg::fpc_fmt_t f, input logic [95:0] a,
                            input fpc_pkg::fpc_class_t c, input logic s);
        logic tr;
        tr = (c == fpc_pkg::FPC_DENRM) || (c == fpc_pkg::FPC_UNNRM);
        apply(f, a, '0, 1'b0, 1'b0);
        chk_cls("info_a_q.cls", c, info_a_q.cls);
        chk_bit("info_a_q.sign", s, info_a_q.sign);
        chk_bit("unimp_trap_q", tr, unimp_trap_q);
        chk_cls("info_b_q.cls", fpc_pkg::FPC_ZERO, info_b_q.cls);
    endtask : cls_case
    // nan result, word and event
    task automatic nan_case(input fpc_pkg::fpc_fmt_t f, input logic [95:0] a,
        input logic [95:0] b, input logic inv, trap, o, ev,
        input logic [95:0] w);
        apply(f, a, b, inv, trap);
        chk_bit("nan_out_q", o, nan_out_q);
        chk_word("nan_word_q", w, nan_word_q);
        chk_bit("snan_event_q", ev, snan_event_q);
    endtask : nan_case
    // single result in range or over
    task automatic rng_case(input logic [16:0] e, input logic ov, input int g);
        u_src.send(SGL, {1'b0, e, 64'h8000_0000_0000_0000}, g);
        chk_bit("ovfl_q", ov, ovfl_q);
        chk_bit("unfl_q", 1'b0, unfl_q);
        chk_bit("res_done_q", 1'b1, res_done_q);
    endtask : rng_case
    // gradual underflow, one shift a cycle
    task automatic uf_case(input logic [16:0] e, input logic [63:0] m,
        input int n, input logic [63:0] em);
        u_src.send(SGL, {1'b1, e, m}, 1);
        chk_bit("unfl_q", 1'b1, unfl_q);
        chk_bit("res_busy", 1'b1, res_busy);
        for (int i = 0; i < n + 1; i++) begin
            chk_bit("res_done_q", 1'b0, res_done_q);
            @(posedge core_clk);
            #1;
        end
        chk_bit("res_done_q", 1'b1, res_done_q);
        chk_word("res_out_q.exp", 96'h0, {79'h0, res_out_q.exp});
        chk_word("res_out_q.man", {32'h0, em}, {32'h0, res_out_q.man});
        chk_bit("res_out_q.sign", 1'b1, res_out_q.sign);
    endtask : uf_case

    // ======================================================
    // clock, reset, watchdog, main sequence
    // ======================================================
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {resetn, op_valid, invalid_op, snan_trap_en} = 4'h0;
        op_fmt = SGL;
        {op_a, op_b} = '0;
        repeat (2) @(posedge core_clk);
        #1;
        chk_cls("reset cls", fpc_pkg::FPC_ZERO, info_a_q.cls);
        resetn = 1'b1;
        cls_case(SGL, 96'h3f80_0000, fpc_pkg::FPC_NORM, 0);
        cls_case(SGL, 96'h0080_0000, fpc_pkg::FPC_NORM, 0);
        cls_case(SGL, 96'h7f7f_ffff, fpc_pkg::FPC_NORM, 0);
        cls_case(SGL, 96'h8000_0001, fpc_pkg::FPC_DENRM, 1);
        cls_case(SGL, 96'h8000_0000, fpc_pkg::FPC_ZERO, 1);
        cls_case(SGL, 96'hff80_0000, fpc_pkg::FPC_INF, 1);
        cls_case(SGL, 96'hffc0_0000, fpc_pkg::FPC_QNAN, 1);
        cls_case(SGL, 96'h7f80_0001, fpc_pkg::FPC_SNAN, 0);
        cls_case(DBL, 96'h000f_ffff_ffff_ffff, fpc_pkg::FPC_DENRM, 0);
        cls_case(DBL, 96'hfff0_0000_0000_0000, fpc_pkg::FPC_INF, 1);
        cls_case(EXT, 96'h8000_0000_0000_0000, fpc_pkg::FPC_NORM, 0);
        cls_case(EXT, 96'h0001_0000_0000_0000_0000_0001,
                 fpc_pkg::FPC_UNNRM, 0);
        cls_case(EXT, 96'h0001_0000_0000_0000_0000_0000,
                 fpc_pkg::FPC_UNNRM, 0);
        cls_case(EXT, 96'h1, fpc_pkg::FPC_DENRM, 0);
        cls_case(EXT, 96'h7fff_0000_0000_0000_0000_0000,
                 fpc_pkg::FPC_INF, 0);
        cls_case(EXT, 96'hffff_0000_4000_0000_0000_0000,
                 fpc_pkg::FPC_QNAN, 1);
        cls_case(PKD, 96'h1, fpc_pkg::FPC_NORM, 0);
        nan_case(SGL, 96'h7f80_0001, 96'h0, 0, 0, 1, 1,
                 96'h7fc0_0001);
        nan_case(SGL, 96'h7f80_0001, 96'h0, 0, 1, 0, 1, 96'h0);
        nan_case(SGL, 96'h3f80_0000, 96'h0, 1, 0, 1, 0,
                 96'h7fff_ffff);
        nan_case(EXT, 96'h0, 96'h0, 1, 0, 1, 0,
                 96'h7fff_0000_ffff_ffff_ffff_ffff);
        nan_case(EXT, 96'hffff_0000_8000_0000_0000_0001,
                 96'h0, 0, 0, 1, 1, 96'hffff_0000_c000_0000_0000_0001);
        nan_case(DBL, 96'h7ff8_0000_0000_0001, 96'h7ff0_0000_0000_0001,
                 0, 0, 1, 1, 96'h7ff8_0000_0000_0001);
        rng_case(17'h0007f, 1'b0, 0);
        rng_case(17'h00001, 1'b0, 3);
        rng_case(17'h000ff, 1'b1, 0);
        rng_case(17'h00100, 1'b1, 2);
        // shifts, and all bits shifted out gives zero
        uf_case(17'h1ffff, 64'h8000_0000_0000_0000, 1,
                64'h4000_0000_0000_0000);
        uf_case(17'h1fffe, 64'h2, 2, 64'h0);
        uf_case(17'h1fff0, 64'h1, 1, 64'h0);
        uf_case(17'h00000, 64'h8000_0000_0000_0000, 0,
                64'h8000_0000_0000_0000);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
